/* File: bus_timing_pkg.sv */
package bus_timing_pkg;

   // register byte addresses on the APB side
   localparam logic [15:0] WRITE_CFG_ADDR   = 16'hF900;
   localparam logic [15:0] ZONE0_CFG_ADDR   = 16'hF904;
   localparam logic [15:0] PORT_CFG_ADDR    = 16'hF908;
   localparam logic [15:0] MODULE_CFG_ADDR  = 16'hF90C;
   localparam logic [15:0] STATUS_ADDR      = 16'hF910;

   // reset values
   localparam logic [15:0] ZONE0_CFG_RESET  = 16'h069F;
   localparam logic [15:0] PORT_CFG_RESET   = 16'h069F;
   localparam logic [15:0] WRITE_CFG_RESET  = 16'h0007;
   localparam logic [15:0] MODULE_CFG_RESET = 16'h0000;

   // writable bits; the rest read as zero
   localparam logic [15:0] ZONE_CFG_MASK    = 16'h0EFF;
   localparam logic [15:0] WRITE_CFG_MASK   = 16'h0007;
   localparam logic [15:0] MODULE_CFG_MASK  = 16'h0001;

   // field positions in the zone, write cycle and module register layouts
   localparam int WAIT_LSB        = 0;
   localparam int WAIT_W          = 3;
   localparam int HOLD_LSB        = 3;
   localparam int HOLD_W          = 2;
   localparam int BUS_WIDTH_BIT   = 7;
   localparam int POST_IDLE_BIT   = 9;
   localparam int PRE_IDLE_BIT    = 10;
   localparam int FAST_READ_BIT   = 11;
   localparam int EARLY_WRITE_BIT = 0;
   localparam int EEPROM_FAST_BIT = 0;

   // address regions
   localparam logic [15:0] FLASH_LO  = 16'h0000;
   localparam logic [15:0] FLASH_HI  = 16'hBFFF;
   localparam logic [15:0] RAM_LO    = 16'hE000;
   localparam logic [15:0] RAM_HI    = 16'hE7FF;
   localparam logic [15:0] EEPROM_LO = 16'hF000;
   localparam logic [15:0] EEPROM_HI = 16'hF27F;
   localparam logic [15:0] PERIPH_LO = 16'hF000;
   localparam logic [15:0] PERIPH_HI = 16'hFFFF;
   localparam logic [15:0] PORT_LO   = 16'hFB00;
   localparam logic [15:0] PORT_HI   = 16'hFBFF;

   // cycle counts
   localparam int          WAIT_CNT_W  = 4;
   localparam logic [3:0]  ONE_WAIT    = 4'h1;
   localparam logic [3:0]  NO_WAIT     = 4'h0;
   localparam logic [1:0]  NO_HOLD     = 2'h0;

   typedef enum logic [2:0] {
      REG_NONE,
      REG_FLASH,
      REG_RAM,
      REG_EEPROM,
      REG_PERIPH,
      REG_PORT
   } region_t;

endpackage

/* File: zone_decode.sv */
`timescale 1ns/10ps
module zone_decode (
   input  wire logic [15:0]               addr,
   output bus_timing_pkg::region_t         region
);

   function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
      inRange = (a >= lo) && (a <= hi);
   endfunction

   // narrow windows first so they win over the general peripheral span
   always_comb begin
      if (inRange(addr, bus_timing_pkg::PORT_LO, bus_timing_pkg::PORT_HI)) begin
         region = bus_timing_pkg::REG_PORT;
      end else if (inRange(addr, bus_timing_pkg::EEPROM_LO, bus_timing_pkg::EEPROM_HI)) begin
         region = bus_timing_pkg::REG_EEPROM;
      end else if (inRange(addr, bus_timing_pkg::RAM_LO, bus_timing_pkg::RAM_HI)) begin
         region = bus_timing_pkg::REG_RAM;
      end else if (inRange(addr, bus_timing_pkg::FLASH_LO, bus_timing_pkg::FLASH_HI)) begin
         region = bus_timing_pkg::REG_FLASH;
      end else if (inRange(addr, bus_timing_pkg::PERIPH_LO, bus_timing_pkg::PERIPH_HI)) begin
         region = bus_timing_pkg::REG_PERIPH;
      end else begin
         region = bus_timing_pkg::REG_NONE;
      end
   end

endmodule

/* File: cycle_calc.sv */
`timescale 1ns/10ps
module cycle_calc (
   input  wire logic [15:0]               zone0Cfg,
   input  wire logic [15:0]               portCfg,
   input  wire logic                      earlyWrite,
   input  wire logic                      eepromFast,
   input  wire bus_timing_pkg::region_t   region,
   input  wire logic                      isWrite,
   output logic [3:0]                     waitCount,
   output logic [1:0]                     holdCount,
   output logic                           fastCycle,
   output logic                           wideBus
);

   function automatic logic [3:0] waitField(input logic [15:0] cfg);
      waitField = {1'b0, cfg[bus_timing_pkg::WAIT_LSB +: bus_timing_pkg::WAIT_W]};
   endfunction

   logic [3:0] early_write_select;
   logic       fast_read_select;

   assign early_write_select = {3'h0, earlyWrite};
   assign fast_read_select = zone0Cfg[bus_timing_pkg::FAST_READ_BIT];

   // wait and hold counts per region and direction
   always_comb begin
      waitCount = bus_timing_pkg::NO_WAIT;
      holdCount = bus_timing_pkg::NO_HOLD;
      fastCycle = 1'b0;
      wideBus   = 1'b1;
      case (region)
         bus_timing_pkg::REG_FLASH: begin
            wideBus = zone0Cfg[bus_timing_pkg::BUS_WIDTH_BIT];
            if (!isWrite && fast_read_select) begin
               fastCycle = 1'b1;
            end else if (!isWrite) begin
               waitCount = bus_timing_pkg::ONE_WAIT + waitField(zone0Cfg);
               holdCount = zone0Cfg[bus_timing_pkg::HOLD_LSB +: bus_timing_pkg::HOLD_W];
            end else if (fast_read_select) begin
               waitCount = bus_timing_pkg::ONE_WAIT + early_write_select;
            end else begin
               waitCount = bus_timing_pkg::ONE_WAIT + early_write_select + waitField(zone0Cfg);
               holdCount = zone0Cfg[bus_timing_pkg::HOLD_LSB +: bus_timing_pkg::HOLD_W];
            end
         end
         bus_timing_pkg::REG_RAM: begin
            waitCount = bus_timing_pkg::NO_WAIT;
         end
         bus_timing_pkg::REG_EEPROM: begin
            // writes take the plain peripheral wait
            waitCount = (!isWrite && eepromFast) ? bus_timing_pkg::NO_WAIT
                                                 : bus_timing_pkg::ONE_WAIT;
         end
         bus_timing_pkg::REG_PERIPH: begin
            waitCount = bus_timing_pkg::ONE_WAIT;
         end
         bus_timing_pkg::REG_PORT: begin
            wideBus   = portCfg[bus_timing_pkg::BUS_WIDTH_BIT];
            waitCount = isWrite ? bus_timing_pkg::ONE_WAIT + early_write_select + waitField(portCfg)
                                : bus_timing_pkg::ONE_WAIT + waitField(portCfg);
            holdCount = portCfg[bus_timing_pkg::HOLD_LSB +: bus_timing_pkg::HOLD_W];
         end
         default: begin
            waitCount = bus_timing_pkg::NO_WAIT;
         end
      endcase
   end

endmodule

/* File: bus_wait_hold_timing_unit.sv */
// What this block does
// - zone-0 timing register at F904, 16 bits, bits 0-7 and 9-11 read/write, resets to 069F.
// - three-bit wait field gives zero to seven extra internal wait cycles.
// - two-bit hold field gives zero to three hold cycles after each access.
// - bus width bit: clear means 8-bit bus, set means 16-bit, reset 16.
// - post idle bit adds one idle cycle when the next access changes zone.
// - pre idle bit adds one idle cycle before an access in a new zone.
// - fast read bit set gives one-cycle reads, clear gives reads of three or more.
// - fast flash reads use no waits and no holds, ignoring both fields.
// - normal flash reads wait one plus wait field, hold per hold field.
// - flash writes in fast mode wait one plus early-write bit, no hold.
// - flash writes in normal mode wait field plus one or two, hold field.
// - static RAM accesses add no waits and no holds.
// - EEPROM reads wait zero when fast bit set, else one; never hold.
// - core register and peripheral accesses wait exactly one, no hold.
// - port region wait, hold and bus width come from the port zone register fields; its idle and fast read bits go unused.
// - early write select: clear gives late writes, set early; resets early.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module bus_wait_hold_timing_unit #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // APB register port
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // CPU core side
   input  wire logic                  cpuReq,
   input  wire logic                  cpuWrite,
   input  wire logic                  cpuWord,
   input  wire logic [ADDR_W-1:0]     cpuAddr,
   input  wire logic [DATA_W-1:0]     cpuWdata,
   output logic                       cpuReady,
   output logic [DATA_W-1:0]          cpuRdata,
   // memory and peripheral side
   output logic                       memStrobe,
   output logic                       memLatch,
   output logic                       memHold,
   output logic                       memIdle,
   output logic                       memWrite,
   output logic                       memWord,
   output logic [ADDR_W-1:0]          memAddr,
   output logic [DATA_W-1:0]          memWdata,
   input  wire logic [DATA_W-1:0]     memRdata
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_GAP,
      ST_ADDR,
      ST_WAIT,
      ST_DATA,
      ST_HOLD,
      ST_ACK
   } seq_state_t;

   // configuration registers
   logic [15:0]               zone0Cfg;
   logic [15:0]               portCfg;
   logic [15:0]               writeCfg;
   logic [15:0]               moduleCfg;

   // sequencer state
   seq_state_t                state;
   bus_timing_pkg::region_t   reqRegion;
   bus_timing_pkg::region_t   lastRegion;
   logic                      lastValid;
   logic [3:0]                waitLoad;
   logic [3:0]                waitLeft;
   logic [1:0]                holdLoad;
   logic [1:0]                holdLeft;
   logic [1:0]                gapLeft;
   logic                      reqFast;
   logic                      reqSplit;
   logic                      half;
   logic [DATA_W-1:0]         reqWdata;
   logic [7:0]                rdataLow;
   logic                      lastSplit;
   logic                      lastGap;

   // decode and timing for the request now offered
   bus_timing_pkg::region_t   curRegion;
   logic [3:0]                curWait;
   logic [1:0]                curHold;
   logic                      curFast;
   logic                      curWide;
   logic [1:0]                curGap;
   logic                      zoneChange;
   logic                      accessDone;
   logic                      apbSetup;
   logic                      apbWriteEn;
   logic [15:0]               apbAddr;
   logic [15:0]               statusWord;

   zone_decode u_decode (
      .addr   (cpuAddr[15:0]),
      .region (curRegion)
   );

   cycle_calc u_calc (
      .zone0Cfg   (zone0Cfg),
      .portCfg    (portCfg),
      .earlyWrite (writeCfg[bus_timing_pkg::EARLY_WRITE_BIT]),
      .eepromFast (moduleCfg[bus_timing_pkg::EEPROM_FAST_BIT]),
      .region     (curRegion),
      .isWrite    (cpuWrite),
      .waitCount  (curWait),
      .holdCount  (curHold),
      .fastCycle  (curFast),
      .wideBus    (curWide)
   );

   function automatic logic [1:0] bit2(input logic b);
      bit2 = {1'b0, b};
   endfunction

   // APB decode; zero-wait slave, read data prepared during the setup phase
   assign apbAddr    = paddr[15:0];
   assign apbSetup   = psel & ~penable;
   assign apbWriteEn = psel & penable & pwrite;
   assign pready     = 1'b1;

   // one idle cycle per enabled idle bit when the zone changes
   assign zoneChange = lastValid && (curRegion != lastRegion);
   assign curGap     = zoneChange ? bit2(zone0Cfg[bus_timing_pkg::POST_IDLE_BIT])
                                    + bit2(zone0Cfg[bus_timing_pkg::PRE_IDLE_BIT])
                                  : 2'h0;

   // last cycle of a bus half: data cycle without hold, last hold, or a fast read
   assign accessDone = ((state == ST_DATA) && (holdLoad == 2'h0))
                    || ((state == ST_HOLD) && (holdLeft == 2'h1))
                    || ((state == ST_ADDR) && reqFast);

   // zone-0 register; bits outside the mask stay zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         zone0Cfg <= bus_timing_pkg::ZONE0_CFG_RESET;
      end else if (apbWriteEn && (apbAddr == bus_timing_pkg::ZONE0_CFG_ADDR)) begin
         // bits 5 and 6 are stored as written; software keeps them zero
         zone0Cfg <= pwdata[15:0] & bus_timing_pkg::ZONE_CFG_MASK;
      end
   end

   // port zone register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         portCfg <= bus_timing_pkg::PORT_CFG_RESET;
      end else if (apbWriteEn && (apbAddr == bus_timing_pkg::PORT_CFG_ADDR)) begin
         portCfg <= pwdata[15:0] & bus_timing_pkg::ZONE_CFG_MASK;
      end
   end

   // write cycle register; reset selects early writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         writeCfg <= bus_timing_pkg::WRITE_CFG_RESET;
      end else if (apbWriteEn && (apbAddr == bus_timing_pkg::WRITE_CFG_ADDR)) begin
         writeCfg <= pwdata[15:0] & bus_timing_pkg::WRITE_CFG_MASK;
      end
   end

   // module register holding the fast EEPROM bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         moduleCfg <= bus_timing_pkg::MODULE_CFG_RESET;
      end else if (apbWriteEn && (apbAddr == bus_timing_pkg::MODULE_CFG_ADDR)) begin
         moduleCfg <= pwdata[15:0] & bus_timing_pkg::MODULE_CFG_MASK;
      end
   end

   // read-only view of the sequencer and the last completed access
   assign statusWord = {4'h0, lastGap, lastSplit, holdLoad, waitLoad,
                        reqRegion, (state != ST_IDLE)};

   // read mux, latched in the setup phase so prdata comes from a flop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (apbSetup) begin
         pslverr <= 1'b0;
         case (apbAddr)
            bus_timing_pkg::ZONE0_CFG_ADDR:  prdata <= {16'h0000, zone0Cfg};
            bus_timing_pkg::PORT_CFG_ADDR:   prdata <= {16'h0000, portCfg};
            bus_timing_pkg::WRITE_CFG_ADDR:  prdata <= {16'h0000, writeCfg};
            bus_timing_pkg::MODULE_CFG_ADDR: prdata <= {16'h0000, moduleCfg};
            bus_timing_pkg::STATUS_ADDR:     prdata <= {16'h0000, statusWord};
            default: begin
               prdata  <= 32'h0000_0000;
               pslverr <= 1'b1;  // unmapped: error, write ignored
            end
         endcase
      end
   end

   // sequencer; timing is snapshotted at the start so a mid-access config write
   // only affects the next access
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cpuReq) begin
                  state <= (curGap != 2'h0) ? ST_GAP : ST_ADDR;
               end
            end
            ST_GAP: begin
               if (gapLeft == 2'h1) begin
                  state <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (reqFast) begin
                  state <= (reqSplit && !half) ? ST_ADDR : ST_ACK;
               end else if (waitLoad != 4'h0) begin
                  state <= ST_WAIT;
               end else begin
                  state <= ST_DATA;
               end
            end
            ST_WAIT: begin
               if (waitLeft == 4'h1) begin
                  state <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (holdLoad != 2'h0) begin
                  state <= ST_HOLD;
               end else begin
                  state <= (reqSplit && !half) ? ST_ADDR : ST_ACK;
               end
            end
            ST_HOLD: begin
               if (holdLeft == 2'h1) begin
                  state <= (reqSplit && !half) ? ST_ADDR : ST_ACK;
               end
            end
            ST_ACK: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // request snapshot taken when the access is accepted
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reqRegion <= bus_timing_pkg::REG_NONE;
         waitLoad  <= 4'h0;
         holdLoad  <= 2'h0;
         reqFast   <= 1'b0;
         reqSplit  <= 1'b0;
         reqWdata  <= '0;
         memWrite  <= 1'b0;
         memWord   <= 1'b0;
      end else if ((state == ST_IDLE) && cpuReq) begin
         reqRegion <= curRegion;
         waitLoad  <= curWait;
         holdLoad  <= curHold;
         reqFast   <= curFast;
         reqSplit  <= cpuWord && !curWide;
         reqWdata  <= cpuWdata;
         memWrite  <= cpuWrite;
         memWord   <= cpuWord && curWide;
      end
   end

   // idle, wait and hold counters
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gapLeft  <= 2'h0;
         waitLeft <= 4'h0;
         holdLeft <= 2'h0;
      end else begin
         if ((state == ST_IDLE) && cpuReq) begin
            gapLeft <= curGap;
         end else if (state == ST_GAP) begin
            gapLeft <= gapLeft - 2'h1;
         end
         if (state == ST_ADDR) begin
            waitLeft <= waitLoad;
         end else if (state == ST_WAIT) begin
            waitLeft <= waitLeft - 4'h1;
         end
         if (state == ST_DATA) begin
            holdLeft <= holdLoad;
         end else if (state == ST_HOLD) begin
            holdLeft <= holdLeft - 2'h1;
         end
      end
   end

   // byte halves on a narrow bus: low byte first, then the next address
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         half      <= 1'b0;
         memAddr   <= '0;
         memWdata  <= '0;
      end else if ((state == ST_IDLE) && cpuReq) begin
         half      <= 1'b0;
         memAddr   <= cpuAddr;
         memWdata  <= cpuWdata;
      end else if (accessDone && reqSplit && !half) begin
         half      <= 1'b1;
         memAddr   <= memAddr + ADDR_W'(1);
         memWdata  <= {8'h00, reqWdata[15:8]};
      end
   end

   // read data capture at the data cycle, or the address cycle of a fast read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdataLow <= 8'h00;
         cpuRdata <= '0;
      end else if (memLatch && !memWrite) begin
         if (reqSplit && !half) begin
            rdataLow <= memRdata[7:0];
         end else if (reqSplit) begin
            cpuRdata <= {memRdata[7:0], rdataLow};
         end else begin
            cpuRdata <= memRdata;
         end
      end
   end

   // zone history for the idle insertion, plus status of the last access
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lastRegion <= bus_timing_pkg::REG_NONE;
         lastValid  <= 1'b0;
         lastSplit  <= 1'b0;
         lastGap    <= 1'b0;
      end else if (state == ST_ACK) begin
         lastRegion <= reqRegion;
         lastValid  <= 1'b1;
         lastSplit  <= reqSplit;
         // lastGap is left alone so status still shows an idle used by this access
      end else if (state == ST_GAP) begin
         lastGap    <= 1'b1;
      end else if ((state == ST_IDLE) && cpuReq) begin
         lastGap    <= 1'b0;
      end
   end

   // bus phase strobes decoded from the state flop
   assign memStrobe = (state == ST_ADDR) || (state == ST_WAIT)
                   || (state == ST_DATA) || (state == ST_HOLD);
   assign memLatch  = (state == ST_DATA) || ((state == ST_ADDR) && reqFast);
   assign memHold   = (state == ST_HOLD);
   assign memIdle   = (state == ST_GAP);
   assign cpuReady  = (state == ST_ACK);

endmodule

/* File: bus_wait_hold_timing_unit_checker.sv */
`timescale 1ns/10ps
module bus_wait_hold_timing_unit_checker #(
   parameter int ADDR_W = 16
) (
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              cpuReady,
   input wire logic              memStrobe,
   input wire logic              memLatch,
   input wire logic              memHold,
   input wire logic              memIdle,
   input wire logic [ADDR_W-1:0] memAddr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic mapped;
   logic inRam;
   logic inPeriph;
   // decode kept apart from the design so a shared slip cannot hide
   assign mapped = paddr inside {16'hF900, 16'hF904, 16'hF908, 16'hF90C, 16'hF910};
   assign inRam = memAddr inside {[16'hE000:16'hE7FF]};
   assign inPeriph = memAddr inside {[16'hF280:16'hFAFF], [16'hFC00:16'hFFFF]};
   // address cycle, data cycle, then the ready cycle with the bus released
   sequence noWaitCycle;
      !memLatch ##1 memLatch ##1 (cpuReady && !memStrobe);
   endsequence
   sequence oneWaitCycle;
      !memLatch ##1 !memLatch ##1 memLatch ##1 (cpuReady && !memStrobe);
   endsequence
   AST_PREADY: assert property (pready) else $error("pready low");
   AST_UNMAPPED: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (psel && penable && mapped |-> !pslverr)
      else $error("mapped access refused");
   AST_READY_PULSE: assert property (cpuReady |=> !cpuReady) else $error("ready too long");
   AST_READY_AFTER_BUS: assert property (cpuReady |-> $past(memStrobe) && !memStrobe)
      else $error("ready not after bus cycle");
   AST_LATCH_STROBE: assert property (memLatch |-> memStrobe) else $error("latch off bus");
   AST_HOLD: assert property (memHold |-> memStrobe && !memLatch) else $error("bad hold");
   AST_IDLE: assert property (memIdle |-> !memStrobe && !cpuReady) else $error("bad idle");
   AST_RAM: assert property ($rose(memStrobe) && inRam |-> noWaitCycle)
      else $error("ram access timing wrong");
   AST_PERIPH: assert property ($rose(memStrobe) && inPeriph |-> oneWaitCycle)
      else $error("peripheral access timing wrong");
endmodule
bind bus_wait_hold_timing_unit bus_wait_hold_timing_unit_checker #(.ADDR_W(ADDR_W)) chk (
   .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuReady(cpuReady),
   .memStrobe(memStrobe), .memLatch(memLatch), .memHold(memHold), .memIdle(memIdle),
   .memAddr(memAddr));

/* File: mem_responder.sv */
`timescale 1ns/10ps
module mem_responder (
   input  wire logic        memStrobe,
   input  wire logic [15:0] memAddr,
   output logic      [15:0] memRdata
);
   // a deselected bus shows the inverse word, so a sample taken off the strobe never matches
   assign memRdata = memStrobe ? (memAddr ^ 16'h5AA5) : ~(memAddr ^ 16'h5AA5);
endmodule

/* File: bus_wait_hold_timing_unit_bench.sv */
`timescale 1ns/10ps
module bus_wait_hold_timing_unit_bench;
   logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic cpuReq = 1'b0, cpuWrite = 1'b0, cpuWord = 1'b0, narrow = 1'b0;
   logic [15:0] paddr = 16'h0000, cpuAddr = 16'h0000, cpuWdata = 16'h0000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, cpuReady, memStrobe, memLatch, memHold, memIdle, memWrite, memWord;
   logic [15:0] cpuRdata, memAddr, memWdata, memRdata;
   int errors = 0, comparisons = 0;
   bus_wait_hold_timing_unit DUT (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuWord(cpuWord),
      .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuReady(cpuReady), .cpuRdata(cpuRdata),
      .memStrobe(memStrobe), .memLatch(memLatch), .memHold(memHold), .memIdle(memIdle),
      .memWrite(memWrite), .memWord(memWord), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata));
   mem_responder mem (.memStrobe(memStrobe), .memAddr(memAddr), .memRdata(memRdata));
   // 200 MHz
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 16'h0000, rd, err);
      check("prdata", exp, rd);
      check("pslverr", {31'h0, expErr}, {31'h0, err});
   endtask
   // cyc is the cycle of the ready pulse, counting the raise cycle as zero
   task automatic acc(input logic w, input logic wd, input logic [15:0] a, input int cyc);
      int n;
      logic [15:0] ed;
      logic [15:0] hi;
      n = 0;
      cpuReq <= 1'b1;
      cpuWrite <= w;
      cpuWord <= wd;
      cpuAddr <= a;
      cpuWdata <= ~a;
      do begin
         @(posedge clk);
         n++;
      end while (cpuReady !== 1'b1 && n < 200);
      cpuReq <= 1'b0;
      check("cycles", 32'(cyc), 32'(n - 1));
      check("memWrite", 32'(w), 32'(memWrite));
      check("memWord", 32'(wd && !narrow), 32'(memWord));
      if (w) check("memWdata", {16'h0000, ~a}, {16'h0000, memWdata});
      if (!w && wd) begin
         ed = a ^ 16'h5AA5;
         hi = (a + 16'h0001) ^ 16'h5AA5;
         if (narrow) ed = {hi[7:0], ed[7:0]};
         check("cpuRdata", {16'h0000, ed}, {16'h0000, cpuRdata});
      end
      @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdchk(16'hF904, 32'h069F, 1'b0);
      rdchk(16'hF900, 32'h0007, 1'b0);
      rdchk(16'hF914, 32'h0, 1'b1);
      wr(16'hF904, 16'hFF9F);
      rdchk(16'hF904, 32'h0E9F, 1'b0);
      wr(16'hF904, 16'h0E80);
      wr(16'hF908, 16'h0288);
      rdchk(16'hF904, 32'h0E80, 1'b0);
      rdchk(16'hF908, 32'h0288, 1'b0);
      // wait field 5, hold 2, wide, normal reads, no idle; early write
      wr(16'hF908, 16'h0081);
      wr(16'hF904, 16'h0095);
      acc(1'b0, 1'b1, 16'h1000, 11);
      acc(1'b0, 1'b1, 16'hBFFE, 11);
      acc(1'b1, 1'b1, 16'h1000, 12);
      acc(1'b0, 1'b1, 16'hE7FE, 3);
      acc(1'b1, 1'b1, 16'hE000, 3);
      acc(1'b0, 1'b1, 16'hF27E, 4);
      acc(1'b0, 1'b1, 16'hF280, 4);
      acc(1'b1, 1'b1, 16'hFC00, 4);
      acc(1'b0, 1'b1, 16'hFB10, 5);
      acc(1'b1, 1'b1, 16'hFBFE, 6);
      acc(1'b0, 1'b1, 16'hE800, 3);
      // late write, fast eeprom, fast flash reads
      wr(16'hF900, 16'h0006);
      wr(16'hF90C, 16'h0001);
      wr(16'hF904, 16'h089D);
      acc(1'b0, 1'b1, 16'h0100, 2);
      acc(1'b1, 1'b1, 16'h0100, 4);
      acc(1'b0, 1'b1, 16'hF000, 3);
      acc(1'b1, 1'b1, 16'hFB00, 5);
      // narrow zone: a word read is split into two halves
      wr(16'hF904, 16'h0012);
      narrow = 1'b1;
      acc(1'b0, 1'b1, 16'h2000, 15);
      narrow = 1'b0;
      acc(1'b0, 1'b0, 16'h2001, 8);
      acc(1'b1, 1'b0, 16'h2002, 8);
      acc(1'b0, 1'b1, 16'hE000, 3);
      wr(16'hF904, 16'h0480);
      acc(1'b0, 1'b1, 16'h0000, 5);
      acc(1'b0, 1'b1, 16'h0002, 4);
      wr(16'hF904, 16'h0280);
      acc(1'b0, 1'b1, 16'h0004, 4);
      acc(1'b0, 1'b1, 16'hE002, 4);
      // status: idle used, RAM region, no waits, not busy
      rdchk(16'hF910, 32'h0804, 1'b0);
      print_verdict();
   end
endmodule
